// ===== hw/drive_output_message_logic.sv
// Digital output selectors and window status messages with Avalon-MM registers
// Behaviour
// - Each output selects one source or off/on
// - Torque message while filtered current inside window
// - Current passes first-order filter, settable constant
// - Speed condition while speed inside window
// - Speed message only after response delay
// - Second speed threshold feeds fieldbus flag only
// - Target condition inside negative/positive window
// - Target message only after response delay
// - Target message held until position leaves window
// - Following error when position outside tolerance
// - Following error message after response delay
// - Following error message independent of shutdown
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module drive_output_message_logic
    import drive_msg_pkg::*;
#(
    parameter int unsigned NUM_OUT = 4
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic signed [DATA_W-1:0] act_current,
    input wire logic signed [DATA_W-1:0] act_speed,
    input wire logic signed [DATA_W-1:0] act_pos,
    input wire logic signed [DATA_W-1:0] target_pos,
    input wire logic signed [DATA_W-1:0] set_pos,
    input wire logic [SRC_N-1:0] aux_flags,
    output logic [NUM_OUT-1:0] dout,
    output logic spd_thr_reached,
    output logic irq
);
    localparam int unsigned EW = DATA_W + 2;

    // Configuration registers
    logic [DATA_W-1:0] sel_q, sel_d;
    logic [DATA_W-1:0] tq_cmp_q, tq_cmp_d, tq_win_q, tq_win_d;
    logic [FILT_K_W-1:0] tq_k_q, tq_k_d;
    logic [DATA_W-1:0] sp_cmp_q, sp_cmp_d, sp_win_q, sp_win_d, sp_dly_q, sp_dly_d, sp_thr_q, sp_thr_d;
    logic [DATA_W-1:0] tg_neg_q, tg_neg_d, tg_pos_q, tg_pos_d, tg_dly_q, tg_dly_d;
    logic [DATA_W-1:0] fe_neg_q, fe_neg_d, fe_pos_q, fe_pos_d, fe_dly_q, fe_dly_d;
    logic [MSG_N-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic wait_q, wait_d;
    logic irq_q, irq_d;
    // Message state
    logic signed [DATA_W-1:0] filt_q, filt_d;
    logic signed [DATA_W:0] filt_diff;
    logic signed [DATA_W:0] filt_step;
    logic [MSG_N-1:0] msg_q, msg_d;
    logic tg_hold_q, tg_hold_d;
    logic signed [DATA_W-1:0] tg_lat_q, tg_lat_d;
    logic thr_q, thr_d;
    logic [SRC_N-1:0] src_vec;
    logic [NUM_OUT-1:0] dout_q, dout_d;
    logic tq_in, sp_in, tg_in, tg_in_lat, fe_out, thr_in;
    logic sp_qual, tg_qual, fe_qual;
    logic req, done;

    // Sign-extend to the comparison width
    function automatic logic signed [EW-1:0] ext(input logic [DATA_W-1:0] x);
        ext = {{2{x[DATA_W-1]}}, x};
    endfunction

    // Inclusive window c-lo .. c+hi, computed wide so no wrap occurs
    function automatic logic in_win(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] c,
                                    input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
        in_win = (ext(v) >= ext(c) - ext(lo)) && (ext(v) <= ext(c) + ext(hi));
    endfunction

    // Byte lane merge for Avalon byteenable
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wd,
                                                input logic [3:0] be);
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[8*b +: 8] = wd[8*b +: 8];
        merge = r;
    endfunction

    // Window conditions
    always_comb
    begin
        tq_in = in_win(filt_q, tq_cmp_q, tq_win_q, tq_win_q);
        sp_in = in_win(act_speed, sp_cmp_q, sp_win_q, sp_win_q);
        thr_in = in_win(act_speed, sp_thr_q, sp_win_q, sp_win_q);
        tg_in = in_win(act_pos, target_pos, tg_neg_q, tg_pos_q);
        tg_in_lat = in_win(act_pos, tg_lat_q, tg_neg_q, tg_pos_q);
        fe_out = !in_win(act_pos, set_pos, fe_neg_q, fe_pos_q);
    end

    // Response delay timers, one per qualified message
    msg_qualify #(.CNT_W(DATA_W)) u_sp_qual (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cond(sp_in),
        .delay(sp_dly_q),
        .msg(sp_qual)
    );
    msg_qualify #(.CNT_W(DATA_W)) u_tg_qual (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cond(tg_in),
        .delay(tg_dly_q),
        .msg(tg_qual)
    );
    msg_qualify #(.CNT_W(DATA_W)) u_fe_qual (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cond(fe_out),
        .delay(fe_dly_q),
        .msg(fe_qual)
    );

    // PT1 filter: time constant is 2^k cycles; k of zero passes current straight
    always_comb
    begin
        filt_diff = (DATA_W+1)'(ext(act_current) - ext(filt_q));
        filt_step = filt_diff >>> tq_k_q;
        filt_d = DATA_W'((DATA_W+1)'(ext(filt_q)) + filt_step);
    end

    // Messages; target message latches its centre so a new nearby target keeps it
    always_comb
    begin
        msg_d = '0;
        msg_d[MSG_TQ] = tq_in;
        msg_d[MSG_SP] = sp_qual;
        msg_d[MSG_TG] = tg_hold_q ? tg_in_lat : tg_qual;
        msg_d[MSG_FE] = fe_qual;
        tg_hold_d = tg_hold_q ? tg_in_lat : tg_qual;
        tg_lat_d = tg_hold_q ? tg_lat_q : target_pos;
        thr_d = thr_in;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            filt_q <= RST_ZERO;
            msg_q <= '0;
            tg_hold_q <= 1'b0;
            tg_lat_q <= RST_ZERO;
            thr_q <= 1'b0;
        end
        else
        begin
            filt_q <= filt_d;
            msg_q <= msg_d;
            tg_hold_q <= tg_hold_d;
            tg_lat_q <= tg_lat_d;
            thr_q <= thr_d;
        end
    end

    // Source vector: internal messages replace the matching external flags
    always_comb
    begin
        src_vec = aux_flags;
        src_vec[SRC_OFF] = 1'b0;
        src_vec[SRC_ON] = 1'b1;
        src_vec[SRC_SPEED] = msg_q[MSG_SP];
        src_vec[SRC_TARGET] = msg_q[MSG_TG];
        src_vec[SRC_FOLERR] = msg_q[MSG_FE];
        src_vec[SRC_TORQUE] = msg_q[MSG_TQ];
    end

    // Per-output selector; codes beyond the source list read as off
    for (genvar g = 0; g < NUM_OUT; g++)
    begin : g_out
        logic [SEL_W-1:0] code;
        assign code = sel_q[g*SEL_W +: SEL_W];
        assign dout_d[g] = (32'(code) < SRC_N) ? src_vec[code] : 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            dout_q <= '0;
        else
            dout_q <= dout_d;
    end

    // Bus slave: one wait cycle, read data captured on the first cycle
    always_comb
    begin
        req = avs_read || avs_write;
        done = req && !wait_q;
        wait_d = !(req && wait_q);
        rdata_d = rdata_q;
        if (req && wait_q)
        begin
            unique case (avs_address)
                REG_OUT_SEL: rdata_d = sel_q;
                REG_TQ_CMP: rdata_d = tq_cmp_q;
                REG_TQ_WIN: rdata_d = tq_win_q;
                REG_TQ_FILT: rdata_d = DATA_W'(tq_k_q);
                REG_SP_CMP: rdata_d = sp_cmp_q;
                REG_SP_WIN: rdata_d = sp_win_q;
                REG_SP_DLY: rdata_d = sp_dly_q;
                REG_SP_THR: rdata_d = sp_thr_q;
                REG_TG_NEG: rdata_d = tg_neg_q;
                REG_TG_POS: rdata_d = tg_pos_q;
                REG_TG_DLY: rdata_d = tg_dly_q;
                REG_FE_NEG: rdata_d = fe_neg_q;
                REG_FE_POS: rdata_d = fe_pos_q;
                REG_FE_DLY: rdata_d = fe_dly_q;
                REG_STATUS: rdata_d = DATA_W'({thr_q, msg_q});
                REG_IRQ_STAT: rdata_d = DATA_W'(irq_stat_q);
                REG_IRQ_MASK: rdata_d = DATA_W'(irq_mask_q);
                default: rdata_d = RST_ZERO;
            endcase
        end
    end

    // Register writes take effect on the completing edge; unmapped writes vanish
    always_comb
    begin
        sel_d = sel_q;
        tq_cmp_d = tq_cmp_q;
        tq_win_d = tq_win_q;
        tq_k_d = tq_k_q;
        sp_cmp_d = sp_cmp_q;
        sp_win_d = sp_win_q;
        sp_dly_d = sp_dly_q;
        sp_thr_d = sp_thr_q;
        tg_neg_d = tg_neg_q;
        tg_pos_d = tg_pos_q;
        tg_dly_d = tg_dly_q;
        fe_neg_d = fe_neg_q;
        fe_pos_d = fe_pos_q;
        fe_dly_d = fe_dly_q;
        irq_mask_d = irq_mask_q;
        if (done && avs_write)
        begin
            unique case (avs_address)
                REG_OUT_SEL: sel_d = merge(sel_q, avs_writedata, avs_byteenable);
                REG_TQ_CMP: tq_cmp_d = merge(tq_cmp_q, avs_writedata, avs_byteenable);
                REG_TQ_WIN: tq_win_d = merge(tq_win_q, avs_writedata, avs_byteenable);
                REG_TQ_FILT: tq_k_d = avs_byteenable[0] ? avs_writedata[FILT_K_W-1:0] : tq_k_q;
                REG_SP_CMP: sp_cmp_d = merge(sp_cmp_q, avs_writedata, avs_byteenable);
                REG_SP_WIN: sp_win_d = merge(sp_win_q, avs_writedata, avs_byteenable);
                REG_SP_DLY: sp_dly_d = merge(sp_dly_q, avs_writedata, avs_byteenable);
                REG_SP_THR: sp_thr_d = merge(sp_thr_q, avs_writedata, avs_byteenable);
                REG_TG_NEG: tg_neg_d = merge(tg_neg_q, avs_writedata, avs_byteenable);
                REG_TG_POS: tg_pos_d = merge(tg_pos_q, avs_writedata, avs_byteenable);
                REG_TG_DLY: tg_dly_d = merge(tg_dly_q, avs_writedata, avs_byteenable);
                REG_FE_NEG: fe_neg_d = merge(fe_neg_q, avs_writedata, avs_byteenable);
                REG_FE_POS: fe_pos_d = merge(fe_pos_q, avs_writedata, avs_byteenable);
                REG_FE_DLY: fe_dly_d = merge(fe_dly_q, avs_writedata, avs_byteenable);
                REG_IRQ_MASK: irq_mask_d = avs_byteenable[0] ? avs_writedata[MSG_N-1:0] : irq_mask_q;
                default: sel_d = sel_q;
            endcase
        end
    end

    // Sticky events on message rise; read clears only bits already returned, so set wins
    always_comb
    begin
        irq_stat_d = irq_stat_q;
        if (done && avs_read && avs_address == REG_IRQ_STAT)
            irq_stat_d = irq_stat_q & ~rdata_q[MSG_N-1:0];
        irq_stat_d = irq_stat_d | (msg_d & ~msg_q);
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sel_q <= RST_ZERO;
            tq_cmp_q <= RST_ZERO;
            tq_win_q <= RST_ZERO;
            tq_k_q <= RST_FILT_K;
            sp_cmp_q <= RST_ZERO;
            sp_win_q <= RST_ZERO;
            sp_dly_q <= RST_ZERO;
            sp_thr_q <= RST_ZERO;
            tg_neg_q <= RST_ZERO;
            tg_pos_q <= RST_ZERO;
            tg_dly_q <= RST_ZERO;
            fe_neg_q <= RST_ZERO;
            fe_pos_q <= RST_ZERO;
            fe_dly_q <= RST_ZERO;
            irq_mask_q <= '0;
            irq_stat_q <= '0;
            irq_q <= 1'b0;
            rdata_q <= RST_ZERO;
            wait_q <= 1'b1;
        end
        else
        begin
            sel_q <= sel_d;
            tq_cmp_q <= tq_cmp_d;
            tq_win_q <= tq_win_d;
            tq_k_q <= tq_k_d;
            sp_cmp_q <= sp_cmp_d;
            sp_win_q <= sp_win_d;
            sp_dly_q <= sp_dly_d;
            sp_thr_q <= sp_thr_d;
            tg_neg_q <= tg_neg_d;
            tg_pos_q <= tg_pos_d;
            tg_dly_q <= tg_dly_d;
            fe_neg_q <= fe_neg_d;
            fe_pos_q <= fe_pos_d;
            fe_dly_q <= fe_dly_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
        end
    end

    // Outputs straight from flip-flops
    assign dout = dout_q;
    assign spd_thr_reached = thr_q;
    assign irq = irq_q;
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    AST_SEL_OFF: assert property (sel_q[SEL_W-1:0] == SEL_W'(SRC_OFF) |=> !dout_q[0])
        else $error("output 0 not off when selector is off");
    AST_SEL_ON: assert property (sel_q[SEL_W-1:0] == SEL_W'(SRC_ON) |=> dout_q[0])
        else $error("output 0 not on when selector is on");
    AST_TQ_WIN: assert property (tq_in |=> msg_q[MSG_TQ])
        else $error("torque message missing inside window");
    AST_TQ_OUT: assert property (!tq_in |=> !msg_q[MSG_TQ])
        else $error("torque message outside window");
    AST_FILT_PASS: assert property (tq_k_q == '0 |=> filt_q == $past(act_current))
        else $error("filter with zero constant did not pass current");
    AST_FILT_SLOW: assert property (tq_k_q != '0 && act_current > filt_q |=> filt_q <= $past(act_current))
        else $error("filter overshot the current");
    AST_SP_OUT: assert property (!sp_in |=> !msg_q[MSG_SP])
        else $error("speed message outside window");
    AST_SP_DLY: assert property ($rose(sp_in) && sp_dly_q == 32'h5 ##1 (sp_in && $stable(sp_dly_q))[*5]
        |=> msg_q[MSG_SP])
        else $error("speed message late after delay");
    AST_SP_EARLY: assert property ($rose(sp_in) && sp_dly_q == 32'h5 |=> (!msg_q[MSG_SP])[*5])
        else $error("speed message before delay");
    AST_THR: assert property (thr_in |=> spd_thr_reached)
        else $error("threshold flag missing");
    AST_TG_OUT: assert property (!tg_hold_q && !tg_in |=> !msg_q[MSG_TG])
        else $error("target message outside window");
    AST_TG_DLY: assert property ($rose(tg_in) && !tg_hold_q && tg_dly_q == 32'h3 |=> (!msg_q[MSG_TG])[*3])
        else $error("target message before delay");
    AST_TG_HOLD: assert property (tg_hold_q && tg_in_lat |=> msg_q[MSG_TG])
        else $error("target message dropped inside window");
    AST_FE_IN: assert property (!fe_out |=> !msg_q[MSG_FE])
        else $error("following error inside tolerance");
    AST_FE_NOW: assert property (fe_out && fe_dly_q == '0 |=> msg_q[MSG_FE])
        else $error("following error missing with zero delay");
    AST_SP_DROP: assert property ($fell(sp_in) |=> !msg_q[MSG_SP])
        else $error("speed message not dropped at once");

    COV_TQ: cover property ($rose(msg_q[MSG_TQ]));
    COV_SP: cover property ($rose(msg_q[MSG_SP]));
    COV_TG_HOLD: cover property (tg_hold_q && !tg_in && tg_in_lat);
    COV_IRQ: cover property ($rose(irq_q));
endmodule // drive_output_message_logic

// ===== common/drive_msg_pkg.sv
// Constants shared by the digital output message logic
package drive_msg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned FILT_K_W = 5;
    // Register byte offsets
    localparam logic [7:0] REG_OUT_SEL = 8'h00;
    localparam logic [7:0] REG_TQ_CMP = 8'h04;
    localparam logic [7:0] REG_TQ_WIN = 8'h08;
    localparam logic [7:0] REG_TQ_FILT = 8'h0c;
    localparam logic [7:0] REG_SP_CMP = 8'h10;
    localparam logic [7:0] REG_SP_WIN = 8'h14;
    localparam logic [7:0] REG_SP_DLY = 8'h18;
    localparam logic [7:0] REG_SP_THR = 8'h1c;
    localparam logic [7:0] REG_TG_NEG = 8'h20;
    localparam logic [7:0] REG_TG_POS = 8'h24;
    localparam logic [7:0] REG_TG_DLY = 8'h28;
    localparam logic [7:0] REG_FE_NEG = 8'h2c;
    localparam logic [7:0] REG_FE_POS = 8'h30;
    localparam logic [7:0] REG_FE_DLY = 8'h34;
    localparam logic [7:0] REG_STATUS = 8'h38;
    localparam logic [7:0] REG_IRQ_STAT = 8'h3c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h40;
    // Status, interrupt status and mask bit layout
    localparam int unsigned MSG_TQ = 0;
    localparam int unsigned MSG_SP = 1;
    localparam int unsigned MSG_TG = 2;
    localparam int unsigned MSG_FE = 3;
    localparam int unsigned MSG_N = 4;
    localparam int unsigned STAT_THR = 4;
    // Output source codes, in selector order
    localparam int unsigned SRC_OFF = 0;
    localparam int unsigned SRC_ON = 1;
    localparam int unsigned SRC_I2T = 2;
    localparam int unsigned SRC_SPEED = 3;
    localparam int unsigned SRC_TARGET = 4;
    localparam int unsigned SRC_REMAIN = 5;
    localparam int unsigned SRC_HOM_ACT = 6;
    localparam int unsigned SRC_HOM_VALID = 7;
    localparam int unsigned SRC_UNDERVOLT = 8;
    localparam int unsigned SRC_FOLERR = 9;
    localparam int unsigned SRC_STAGE_EN = 10;
    localparam int unsigned SRC_BRAKE_REL = 11;
    localparam int unsigned SRC_LIN_ID = 12;
    localparam int unsigned SRC_PTRIG1 = 13;
    localparam int unsigned SRC_PTRIG4 = 16;
    localparam int unsigned SRC_SETLOCK = 17;
    localparam int unsigned SRC_TORQUE = 18;
    localparam int unsigned SRC_POSSET = 19;
    localparam int unsigned SRC_READY = 20;
    localparam int unsigned SRC_GEN_ERR = 21;
    localparam int unsigned SRC_N = 22;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [FILT_K_W-1:0] RST_FILT_K = 5'h04;
endpackage

// ===== hw/msg_qualify.sv
// Response delay qualification timer for one message
`timescale 1ns/10ps
module msg_qualify
    import drive_msg_pkg::*;
#(
    parameter int unsigned CNT_W = 32
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cond,
    input wire logic [CNT_W-1:0] delay,
    output logic msg
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic reached;

    // Count while the condition holds, saturate at the delay
    always_comb
    begin
        reached = (cnt_q >= delay);
        if (!cond)
            cnt_d = '0;
        else if (!reached)
            cnt_d = cnt_q + CNT_W'(1);
        else
            cnt_d = cnt_q;
        msg = cond && reached;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule // msg_qualify

// ===== bench/output_reader.sv
// Controller-side model that samples the drive outputs and counts switch-on events
`timescale 1ns/10ps
module output_reader
#(
    parameter int unsigned N = 4
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [N-1:0] dout,
    output logic [7:0] rise_cnt [N]
);
    logic [N-1:0] last_q;
    // Sampled like an input card; a glitch that spans no clock edge is never seen
    always @(posedge clk_sys)
    begin
        last_q <= sys_rst ? '0 : dout;
        for (int g = 0; g < N; g++)
            if (sys_rst) rise_cnt[g] <= 8'h00;
            else if (dout[g] && !last_q[g]) rise_cnt[g] <= rise_cnt[g] + 8'h01;
    end
endmodule // output_reader

// ===== bench/drive_output_message_logic_tb_top.sv
// Self-checking bench for the digital output selectors and window messages
`timescale 1ns/10ps
module drive_output_message_logic_tb_top
    import drive_msg_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic signed [DATA_W-1:0] act_current = 32'sh0, act_speed = 32'sh0, act_pos = 32'sh0;
    logic signed [DATA_W-1:0] target_pos = 32'sh0, set_pos = 32'sh0;
    logic [SRC_N-1:0] aux_flags = '0;
    logic [3:0] dout;
    logic spd_thr_reached;
    logic irq;
    logic [7:0] rise_cnt [4];
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h0000_002b;
    logic [31:0] rd;
    logic [31:0] wsel;
    logic [7:0] r0;
    int c [4];

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    drive_output_message_logic #(.NUM_OUT(4)) drive_output_message_logic_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .act_current(act_current), .act_speed(act_speed), .act_pos(act_pos), .target_pos(target_pos),
        .set_pos(set_pos), .aux_flags(aux_flags), .dout(dout), .spd_thr_reached(spd_thr_reached), .irq(irq));
    output_reader #(.N(4)) output_reader_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .dout(dout), .rise_cnt(rise_cnt));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Reference selector: internal messages, constants, external flags, unused codes low
    function automatic logic exp_out(input int code, input logic [SRC_N-1:0] a, input logic [3:0] m);
        if (code == SRC_OFF) return 1'b0;
        if (code == SRC_ON) return 1'b1;
        if (code == SRC_SPEED) return m[MSG_SP];
        if (code == SRC_TARGET) return m[MSG_TG];
        if (code == SRC_FOLERR) return m[MSG_FE];
        if (code == SRC_TORQUE) return m[MSG_TQ];
        return (code < SRC_N) ? a[code] : 1'b0;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Avalon master: hold until waitrequest sampled low, take data there, then release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Edges until output b is seen high, inputs having changed at the previous edge
    task automatic qual(input int b, input int exp);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (dout[b] !== 1'b1 && n < 300);
        chk("qualify edges", exp, n);
    endtask

    // Message drops two cycles after its condition ends, never later
    task automatic drop(input int b);
        step(2);
        chk("still on", 32'h1, {31'h0, dout[b]});
        step(1);
        chk("dropped", 32'h0, {31'h0, dout[b]});
    endtask

    task automatic results();
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog sized well above the planned sequence
    initial
    begin
        step(20000);
        errors++;
        results();
    end

    initial
    begin
        step(8);
        sys_rst <= 1'b0;
        step(1);
        // Reset values of the writable registers except the interrupt mask, then one unmapped place
        for (int a = 0; a < 14; a++)
        begin
            bus(1'b0, 8'(a * 4), 32'h0);
            chk("reset value", (a == 3) ? 32'h4 : 32'h0, rd);
        end
        bus(1'b1, 8'h44, 32'hffff_ffff);
        bus(1'b0, 8'h44, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Every source code on output 0, random codes and flags elsewhere
        for (int t = 0; t < 24; t++)
        begin
            seed = xs(seed);
            aux_flags <= seed[SRC_N-1:0];
            c[0] = t;
            for (int g = 1; g < 4; g++)
            begin
                seed = xs(seed);
                c[g] = int'(seed % 24);
            end
            wsel = {12'h0, c[3][4:0], c[2][4:0], c[1][4:0], c[0][4:0]};
            bus(1'b1, REG_OUT_SEL, wsel);
            step(3);
            for (int g = 0; g < 4; g++)
                chk("selector", {31'h0, exp_out(c[g], aux_flags, 4'b0111)}, {31'h0, dout[g]});
        end
        // Outputs: speed, target, following error, torque
        act_speed <= 32'sd500;
        act_current <= 32'sd5000;
        bus(1'b1, REG_OUT_SEL, 32'h0009_2483);
        bus(1'b1, REG_SP_CMP, 32'd100);
        bus(1'b1, REG_SP_WIN, 32'd10);
        bus(1'b1, REG_SP_DLY, 32'd5);
        act_speed <= 32'sd110;
        qual(0, 8);
        act_speed <= 32'sd111;
        drop(0);
        r0 = rise_cnt[0];
        for (int k = 0; k < 3; k++)
        begin
            act_speed <= 32'sd90;
            step(4);
            act_speed <= 32'sd89;
            step(3);
        end
        chk("short visits", {24'h0, r0}, {24'h0, rise_cnt[0]});
        act_speed <= 32'sd90;
        qual(0, 8);
        // Target window, latched across a new run
        bus(1'b1, REG_TG_NEG, 32'd5);
        bus(1'b1, REG_TG_POS, 32'd5);
        bus(1'b1, REG_TG_DLY, 32'd3);
        target_pos <= 32'sd1000;
        act_pos <= 32'sd994;
        step(6);
        chk("target outside", 32'h0, {31'h0, dout[1]});
        act_pos <= 32'sd995;
        qual(1, 6);
        target_pos <= 32'sd1004;
        step(10);
        chk("target held", 32'h1, {31'h0, dout[1]});
        act_pos <= 32'sd1006;
        drop(1);
        // Timer ran from the drop edge; three of its edges were spent in drop
        qual(1, 3);
        // Following error outside the tolerance band
        bus(1'b1, REG_FE_NEG, 32'd8);
        bus(1'b1, REG_FE_POS, 32'd8);
        bus(1'b1, REG_FE_DLY, 32'd4);
        set_pos <= 32'sd998;
        step(10);
        chk("no following error", 32'h0, {31'h0, dout[2]});
        set_pos <= 32'sd997;
        qual(2, 7);
        // Torque through the default filter, then unfiltered
        bus(1'b1, REG_TQ_CMP, 32'd200);
        bus(1'b1, REG_TQ_WIN, 32'd50);
        act_current <= 32'sd0;
        step(80);
        act_current <= 32'sd200;
        step(4);
        chk("filter lag", 32'h0, {31'h0, dout[3]});
        step(80);
        chk("torque reached", 32'h1, {31'h0, dout[3]});
        bus(1'b1, REG_TQ_FILT, 32'h0);
        act_current <= 32'sd251;
        step(8);
        chk("torque above", 32'h0, {31'h0, dout[3]});
        act_current <= 32'sd250;
        step(8);
        chk("torque edge", 32'h1, {31'h0, dout[3]});
        // Second threshold reaches the fieldbus flag only
        bus(1'b1, REG_SP_THR, 32'd300);
        act_speed <= 32'sd305;
        step(4);
        chk("threshold flag", 32'h1, {31'h0, spd_thr_reached});
        chk("threshold not on output", 32'h0, {31'h0, dout[0]});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h1d, rd);
        // Interrupt from the speed message only
        bus(1'b1, REG_IRQ_MASK, 32'h2);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        step(2);
        chk("irq idle", 32'h0, {31'h0, irq});
        act_speed <= 32'sd100;
        qual(0, 8);
        step(1);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq status", 32'h2, rd);
        step(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq status empty", 32'h0, rd);
        results();
    end
endmodule // drive_output_message_logic_tb_top
